// file: vpw_pkg.sv
package vpw_pkg;

  // ****************************************************************
  // Register map (byte offsets, one 32-bit word each)
  // ****************************************************************
  localparam logic [5:0] OFF_X = 6'h00;
  localparam logic [5:0] OFF_Y = 6'h04;
  localparam logic [5:0] OFF_MAJOR = 6'h08;
  localparam logic [5:0] OFF_MINOR = 6'h0C;
  localparam logic [5:0] OFF_PATTERN = 6'h10;
  localparam logic [5:0] OFF_PAT_MULT = 6'h14;
  localparam logic [5:0] OFF_DIRECTION = 6'h18;
  localparam logic [5:0] OFF_WRITE_OPTIONS = 6'h1C;
  localparam logic [5:0] OFF_ERROR = 6'h20;
  localparam logic [5:0] OFF_EXECUTE = 6'h24;
  localparam logic [5:0] OFF_STATUS = 6'h28;
  localparam logic [5:0] OFF_LENGTH = 6'h2C;

  // ****************************************************************
  // Widths, field positions, codes
  // ****************************************************************
  localparam int X_W = 10;
  localparam int Y_W = 8;
  localparam int LEN_W = 10;
  localparam logic [1:0] EXEC_CODE = 2'h2;
  localparam int DIR_ARB_BIT = 3;
  localparam int WO_NEGATE_BIT = 0;
  localparam logic [1:0] MODE_OVERLAY = 2'h0;
  localparam logic [1:0] MODE_REPLACE = 2'h1;
  localparam logic [1:0] MODE_COMPLEMENT = 2'h2;
  localparam logic [1:0] MODE_ERASE = 2'h3;
  localparam logic [3:0] PMULT_WRAP = 4'hF;
  localparam int STATUS_RUN_BIT = 0;

  // ****************************************************************
  // Timing: three time states per memory cycle
  // ****************************************************************
  localparam logic [1:0] TS_LAST = 2'h2;
  localparam logic [1:0] TS_WRITE = 2'h1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] PATTERN_RST = 8'hFF;
  localparam logic [3:0] PMULT_RST = 4'hF;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_MODIFY,
    ST_WRITE,
    ST_STEP
  } vpw_state_t;

endpackage

// file: vpw_time_states.sv
module vpw_time_states (
  input wire logic clk_in,        // System clock
  input wire logic resetn_in,     // Async reset, active low
  input wire logic run_in,        // Engine busy
  output logic [1:0] ts_out,      // Time state within memory cycle
  output logic last_out           // Last time state of the cycle
);

  logic [1:0] ts_q;
  logic [1:0] ts_d;

  always_comb begin
    ts_d = 2'h0;
    if (run_in && ts_q != vpw_pkg::TS_LAST) begin
      ts_d = ts_q + 2'h1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ts_q <= 2'h0;
    end else begin
      ts_q <= ts_d;
    end
  end

  assign ts_out = ts_q;
  assign last_out = run_in && ts_q == vpw_pkg::TS_LAST;

endmodule

// file: vpw_modify_table.sv
module vpw_modify_table (
  input wire logic clk_in,        // System clock
  input wire logic resetn_in,     // Async reset, active low
  input wire logic [9:0] addr_in, // Pattern, function, pixel, nibble
  output logic [3:0] data_out     // Registered modified nibble
);

  logic [3:0] data_q;
  logic [3:0] data_d;
  logic pat;
  logic [1:0] mode;
  logic [1:0] pix;
  logic [3:0] hold;

  // 1K by 4 table expressed as logic; only the addressed pixel changes
  always_comb begin
    pat = addr_in[9];
    mode = addr_in[8:7];
    pix = addr_in[5:4];
    hold = addr_in[3:0];
    data_d = hold;
    unique case (mode)
      vpw_pkg::MODE_OVERLAY: data_d[pix] = hold[pix] | pat;
      vpw_pkg::MODE_REPLACE: data_d[pix] = pat;
      vpw_pkg::MODE_COMPLEMENT: data_d[pix] = hold[pix] ^ pat;
      vpw_pkg::MODE_ERASE: data_d[pix] = hold[pix] & ~pat;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_q <= 4'h0;
    end else begin
      data_q <= data_d;
    end
  end

  assign data_out = data_q;

endmodule

// file: vpw_engine.sv
// Contract
// R1: Character is ten parallel eight-bit pattern vectors
// R2: Host loads lengths, options, direction once per character
// R3: Host loads X, Y, pattern before execute
// R4: Execute write code two sets run flag
// R5: Pixel modify is read, modify, write; nine states
// R6: Read at X/Y; X3..X2 pick held nibble
// R7: Table address: pattern, function, X1..X0, held nibble
// R8: Modified nibble written back to same bank
// R9: Down counter decrements per write; zero ends run
// R10: Step X per direction; repeat while count nonzero
// R11: Arbitrary step: minor, major, write, direction; twelve states
// R12: Host preloads minor, major, half-major error
// R13: Minor group adds error, minor, carry; captures carry
// R14: Major group adds major only when carry clear
// R15: Write group writes modified bits at X/Y
// R16: Direction bits address step table; B is direction three
// R17: Carry set steps major only; clear steps both
// R18: No write dir 2 odd line, 6 even line
// R19: No write dir 5/7 even line after 6
// R20: No write dir 1/3 odd line after 2
// R21: Direction bits 2..0 direction, bit 3 arbitrary
// R22: Pattern one modifies pixel; zero leaves it; in replace mode the code writes the zero to the pixel
// R23: Negate bit inverts pattern into table
// R24: Multiplier sets pattern shift rate
// R25: Run flag readable by software
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
module vpw_engine (
  input wire logic clk_in,                // 40 MHz clock
  input wire logic resetn_in,             // Async reset, active low
  input wire logic [5:0] avs_address_in,  // Byte address
  input wire logic avs_read_in,           // Read request
  input wire logic avs_write_in,          // Write request
  input wire logic [31:0] avs_writedata_in, // Write data
  input wire logic [3:0] avs_byteenable_in, // Byte enables
  output logic [31:0] avs_readdata_out,   // Read data
  output logic avs_waitrequest_out,       // Stall
  output logic [13:0] mem_addr_out,       // Screen word address {Y, X9..X4}
  output logic mem_rd_out,                // Screen read strobe
  input wire logic [11:0] mem_rdata_in,   // Screen data, valid next cycle
  output logic mem_wr_out,                // Screen write strobe
  output logic [1:0] mem_bank_out,        // Nibble bank
  output logic [3:0] modified_nibble_out, // Write data
  output logic run_out                    // Vector in progress
);

  // ****************************************************************
  // State
  // ****************************************************************
  vpw_pkg::vpw_state_t state_q, state_d;
  logic [vpw_pkg::X_W-1:0] x_q, x_d;
  logic [vpw_pkg::Y_W-1:0] y_q, y_d;
  logic [vpw_pkg::LEN_W-1:0] major_axis_length_q, major_axis_length_d;
  logic [vpw_pkg::LEN_W-1:0] minor_axis_length_q, minor_axis_length_d;
  logic [vpw_pkg::LEN_W-1:0] err_q, err_d;
  logic [vpw_pkg::LEN_W-1:0] cnt_q, cnt_d;
  logic [7:0] pat_q, pat_d;
  logic [3:0] pmult_q, pmult_d;
  logic [3:0] mcnt_q, mcnt_d;
  logic [7:0] dir_q, dir_d;
  logic [7:0] write_options_q, write_options_d;
  logic [3:0] hold_q, hold_d;
  logic carry_q, carry_d;
  logic [2:0] last_dir_q, last_dir_d;
  logic rd_ack_q, rd_ack_d;
  logic [31:0] rdata_q, rdata_d;

  logic [1:0] ts;
  logic ts_last;
  logic arb;
  logic [2:0] eff_dir;
  logic [3:0] step;
  logic pix_en;
  logic wr_acc;
  logic [3:0] sel_nibble;
  logic [vpw_pkg::LEN_W:0] minor_sum;
  logic do_step;
  logic pat_bit;
  logic [31:0] cur_word;
  logic [15:0] new_word;

  // Basic direction to {dx, dy}, each a two-bit signed step
  function automatic logic [3:0] dir_step(input logic [2:0] d);
    logic [3:0] s;
    unique case (d)
      3'h0: s = {2'h1, 2'h0};
      3'h1: s = {2'h1, 2'h3};
      3'h2: s = {2'h0, 2'h3};
      3'h3: s = {2'h3, 2'h3};
      3'h4: s = {2'h3, 2'h0};
      3'h5: s = {2'h3, 2'h1};
      3'h6: s = {2'h0, 2'h1};
      3'h7: s = {2'h1, 2'h1};
    endcase
    return s;
  endfunction

  vpw_time_states u_ts (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .run_in(run_out),
    .ts_out(ts),
    .last_out(ts_last)
  );

  vpw_modify_table u_table (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .addr_in({pat_bit, write_options_q[2:0], x_q[1:0], hold_q}), // [R7]
    .data_out(modified_nibble_out)
  );

  // ****************************************************************
  // Datapath terms
  // ****************************************************************
  assign run_out = state_q != vpw_pkg::ST_IDLE;
  assign arb = dir_q[vpw_pkg::DIR_ARB_BIT]; // [R21]
  assign pat_bit = pat_q[7] ^ write_options_q[vpw_pkg::WO_NEGATE_BIT]; // [R23] [R22]
  // Octant d..d+1: carry set takes the axis code, clear the diagonal one
  assign eff_dir = !arb ? dir_q[2:0] :
                   (carry_q == dir_q[0]) ? dir_q[2:0] + 3'h1 : dir_q[2:0]; // [R16] [R17]
  assign step = dir_step(eff_dir);
  assign pix_en = !((eff_dir == 3'h2 && y_q[0]) || (eff_dir == 3'h6 && !y_q[0]) // [R18]
                  || ((eff_dir == 3'h5 || eff_dir == 3'h7) && !y_q[0]
                      && last_dir_q == 3'h6) // [R19]
                  || ((eff_dir == 3'h1 || eff_dir == 3'h3) && y_q[0]
                      && last_dir_q == 3'h2)); // [R20]
  assign sel_nibble = x_q[3:2] == 2'h0 ? mem_rdata_in[3:0] :
                      x_q[3:2] == 2'h1 ? mem_rdata_in[7:4] :
                      x_q[3:2] == 2'h2 ? mem_rdata_in[11:8] : 4'h0; // [R6]
  assign minor_sum = {1'b0, err_q} + {1'b0, minor_axis_length_q}
                     + {{vpw_pkg::LEN_W{1'b0}}, carry_q}; // [R13]
  assign wr_acc = avs_write_in && !run_out;
  assign new_word = {avs_byteenable_in[1] ? avs_writedata_in[15:8] : cur_word[15:8],
                     avs_byteenable_in[0] ? avs_writedata_in[7:0] : cur_word[7:0]};
  assign do_step = ts_last && ((state_q == vpw_pkg::ST_WRITE && !arb)
                   || state_q == vpw_pkg::ST_STEP);

  assign mem_addr_out = {y_q, x_q[9:4]}; // [R6]
  assign mem_bank_out = x_q[3:2]; // [R8]
  assign mem_rd_out = state_q == vpw_pkg::ST_READ && ts == 2'h0;
  assign mem_wr_out = state_q == vpw_pkg::ST_WRITE && ts == vpw_pkg::TS_WRITE
                      && pix_en; // [R15] [R8]
  // Setup writes stall while drawing so a vector never sees half-loaded state
  assign avs_waitrequest_out = (avs_read_in && !rd_ack_q) || (avs_write_in && run_out);
  assign avs_readdata_out = rdata_q;

  // Read mux doubles as the old value for partial byte-lane writes
  always_comb begin
    cur_word = 32'h0;
    unique case (avs_address_in)
      vpw_pkg::OFF_X: cur_word[vpw_pkg::X_W-1:0] = x_q;
      vpw_pkg::OFF_Y: cur_word[vpw_pkg::Y_W-1:0] = y_q;
      vpw_pkg::OFF_MAJOR: cur_word[vpw_pkg::LEN_W-1:0] = major_axis_length_q;
      vpw_pkg::OFF_MINOR: cur_word[vpw_pkg::LEN_W-1:0] = minor_axis_length_q;
      vpw_pkg::OFF_PATTERN: cur_word[7:0] = pat_q;
      vpw_pkg::OFF_PAT_MULT: cur_word[3:0] = pmult_q;
      vpw_pkg::OFF_DIRECTION: cur_word[7:0] = dir_q;
      vpw_pkg::OFF_WRITE_OPTIONS: cur_word[7:0] = write_options_q;
      vpw_pkg::OFF_ERROR: cur_word[vpw_pkg::LEN_W-1:0] = err_q;
      vpw_pkg::OFF_STATUS: cur_word[vpw_pkg::STATUS_RUN_BIT] = run_out; // [R25]
      vpw_pkg::OFF_LENGTH: cur_word[vpw_pkg::LEN_W-1:0] = cnt_q;
      default: cur_word = 32'h0;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    x_d = x_q;
    y_d = y_q;
    major_axis_length_d = major_axis_length_q;
    minor_axis_length_d = minor_axis_length_q;
    err_d = err_q;
    cnt_d = cnt_q;
    pat_d = pat_q;
    pmult_d = pmult_q;
    mcnt_d = mcnt_q;
    dir_d = dir_q;
    write_options_d = write_options_q;
    hold_d = hold_q;
    carry_d = carry_q;
    last_dir_d = last_dir_q;
    rd_ack_d = avs_read_in && !rd_ack_q;
    rdata_d = (avs_read_in && !rd_ack_q) ? cur_word : rdata_q;

    if (wr_acc) begin
      unique case (avs_address_in)
        vpw_pkg::OFF_X: x_d = new_word[vpw_pkg::X_W-1:0];
        vpw_pkg::OFF_Y: y_d = new_word[vpw_pkg::Y_W-1:0];
        vpw_pkg::OFF_MAJOR: major_axis_length_d = new_word[vpw_pkg::LEN_W-1:0];
        vpw_pkg::OFF_MINOR: minor_axis_length_d = new_word[vpw_pkg::LEN_W-1:0];
        vpw_pkg::OFF_ERROR: err_d = new_word[vpw_pkg::LEN_W-1:0]; // [R12]
        vpw_pkg::OFF_PATTERN: pat_d = new_word[7:0]; // [R3] [R1]
        vpw_pkg::OFF_PAT_MULT: pmult_d = new_word[3:0];
        vpw_pkg::OFF_DIRECTION: dir_d = new_word[7:0];
        vpw_pkg::OFF_WRITE_OPTIONS: write_options_d = new_word[7:0];
        vpw_pkg::OFF_EXECUTE: begin
          if (avs_byteenable_in[0] && avs_writedata_in[1:0] == vpw_pkg::EXEC_CODE
              && major_axis_length_q != '0) begin
            state_d = vpw_pkg::ST_READ; // [R4]
            cnt_d = major_axis_length_q;
            mcnt_d = pmult_q;
            carry_d = 1'b0;
          end
        end
        default: ;
      endcase
    end

    unique case (state_q)
      vpw_pkg::ST_IDLE: ;
      vpw_pkg::ST_READ: if (ts_last) begin
        hold_d = sel_nibble; // [R6]
        if (arb) begin
          err_d = minor_sum[vpw_pkg::LEN_W-1:0]; // [R13]
          carry_d = minor_sum[vpw_pkg::LEN_W];
        end
        state_d = vpw_pkg::ST_MODIFY; // [R5] [R11]
      end
      vpw_pkg::ST_MODIFY: if (ts_last) begin
        if (arb && !carry_q) begin
          err_d = err_q + major_axis_length_q; // [R14]
        end
        state_d = vpw_pkg::ST_WRITE;
      end
      vpw_pkg::ST_WRITE: if (ts_last) begin
        // Shift rate: wraps at all ones, so 1111 shifts every write
        if (mcnt_q == vpw_pkg::PMULT_WRAP) begin
          pat_d = {pat_q[6:0], pat_q[7]}; // [R24]
          mcnt_d = pmult_q;
        end else begin
          mcnt_d = mcnt_q + 4'h1;
        end
        if (arb) begin
          state_d = vpw_pkg::ST_STEP; // [R11]
        end
      end
      vpw_pkg::ST_STEP: ;
      default: state_d = vpw_pkg::ST_IDLE;
    endcase

    if (do_step) begin
      x_d = x_q + {{(vpw_pkg::X_W-2){step[3]}}, step[3:2]}; // [R10] [R17]
      y_d = y_q + {{(vpw_pkg::Y_W-2){step[1]}}, step[1:0]};
      last_dir_d = eff_dir;
      cnt_d = cnt_q - {{(vpw_pkg::LEN_W-1){1'b0}}, 1'b1}; // [R9]
      state_d = (cnt_q == {{(vpw_pkg::LEN_W-1){1'b0}}, 1'b1}) ?
                vpw_pkg::ST_IDLE : vpw_pkg::ST_READ; // [R9] [R10]
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= vpw_pkg::ST_IDLE;
      x_q <= '0;
      y_q <= '0;
      major_axis_length_q <= '0;
      minor_axis_length_q <= '0;
      err_q <= '0;
      cnt_q <= '0;
      pat_q <= vpw_pkg::PATTERN_RST;
      pmult_q <= vpw_pkg::PMULT_RST;
      mcnt_q <= vpw_pkg::PMULT_RST;
      dir_q <= 8'h00;
      write_options_q <= 8'h00;
      hold_q <= 4'h0;
      carry_q <= 1'b0;
      last_dir_q <= 3'h0;
      rd_ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      state_q <= state_d;
      x_q <= x_d;
      y_q <= y_d;
      major_axis_length_q <= major_axis_length_d;
      minor_axis_length_q <= minor_axis_length_d;
      err_q <= err_d;
      cnt_q <= cnt_d;
      pat_q <= pat_d;
      pmult_q <= pmult_d;
      mcnt_q <= mcnt_d;
      dir_q <= dir_d;
      write_options_q <= write_options_d;
      hold_q <= hold_d;
      carry_q <= carry_d;
      last_dir_q <= last_dir_d;
      rd_ack_q <= rd_ack_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  AST_EXEC_RUN: assert property ((wr_acc && avs_address_in == vpw_pkg::OFF_EXECUTE // [R4]
      && avs_writedata_in[1:0] == vpw_pkg::EXEC_CODE && avs_byteenable_in[0]
      && major_axis_length_q != '0) |=> run_out && state_q == vpw_pkg::ST_READ)
    else $error("execute did not start run");
  AST_NINE_STATES: assert property ((state_q == vpw_pkg::ST_READ && ts == 2'h0) // [R5]
      |-> ##3 state_q == vpw_pkg::ST_MODIFY ##3 state_q == vpw_pkg::ST_WRITE)
    else $error("read-modify-write order broken");
  AST_TWELVE: assert property ((state_q == vpw_pkg::ST_READ && ts == 2'h0 && arb) // [R11]
      |-> ##9 state_q == vpw_pkg::ST_STEP ##3
          (state_q == vpw_pkg::ST_READ || state_q == vpw_pkg::ST_IDLE))
    else $error("arbitrary step not twelve states");
  AST_HOLD: assert property ((state_q == vpw_pkg::ST_READ && ts_last) // [R6]
      |=> hold_q == $past(sel_nibble))
    else $error("holding nibble not strobed");
  AST_WR_TIME: assert property (mem_wr_out // [R8]
      |-> $past(state_q, 4) == vpw_pkg::ST_MODIFY && $past(mem_bank_out, 1) == mem_bank_out)
    else $error("write not after modify");
  AST_END: assert property ((do_step && cnt_q == 10'h001) |=> !run_out) // [R9]
    else $error("run not cleared at zero");
  AST_X_STEP: assert property ((do_step && !arb && dir_q[2:0] == 3'h0) // [R10]
      |=> x_q == $past(x_q) + 10'h001)
    else $error("X not stepped");
  AST_MAJOR_HOLD: assert property ((state_q == vpw_pkg::ST_MODIFY && ts_last // [R14]
      && arb && carry_q) |=> $stable(err_q))
    else $error("error changed with carry set");
  AST_DIR3: assert property ((do_step && dir_q[3:0] == 4'hB && !carry_q) // [R17]
      |=> x_q == $past(x_q) - 10'h001 && y_q == $past(y_q) - 8'h01)
    else $error("direction three both not decremented");
  AST_NO_WR2: assert property ((state_q == vpw_pkg::ST_WRITE && eff_dir == 3'h2 // [R18]
      && y_q[0]) |-> !mem_wr_out)
    else $error("write in direction 2 from odd line");

  COV_BASIC: cover property (run_out && !arb ##1 !run_out);
  COV_ARB: cover property (do_step && arb && carry_q);
  COV_WITHHELD: cover property (state_q == vpw_pkg::ST_WRITE && ts == vpw_pkg::TS_WRITE
      && !pix_en);

endmodule

// file: vpw_screen_model.sv
// ****************************************************************
// Screen memory seen by the pixel writer
// ****************************************************************
module vpw_screen_model (
  input wire logic clk_in,              // System clock
  input wire logic [13:0] mem_addr_in,  // Word address {Y, X9..X4}
  input wire logic mem_rd_in,           // Read strobe
  input wire logic mem_wr_in,           // Write strobe
  input wire logic [1:0] mem_bank_in,   // Nibble bank
  input wire logic [3:0] nibble_in,     // Write data
  output logic [11:0] rdata_out,        // Read data
  output int wr_count_out               // Writes seen so far
);
  logic [11:0] mem [0:16383];
  logic [1:0] hold;

  initial begin
    rdata_out = 12'h000;
    hold = 2'h0;
    wr_count_out = 0;
    foreach (mem[i]) mem[i] = 12'h000;
  end

  always @(posedge clk_in) begin
    if (mem_rd_in) begin
      rdata_out <= mem[mem_addr_in];
      hold <= 2'h2;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else begin
      // Stale data toggles so a late sample cannot pass for a read
      rdata_out <= ~rdata_out;
    end
    if (mem_wr_in) begin
      if (mem_bank_in != 2'h3) begin
        mem[mem_addr_in][{mem_bank_in, 2'h0} +: 4] <= nibble_in;
      end
      wr_count_out <= wr_count_out + 1;
    end
  end
endmodule

// file: vpw_engine_test.sv
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module vpw_engine_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [5:0] avs_address_in = 6'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'h3;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [13:0] mem_addr_out;
  logic mem_rd_out;
  logic [11:0] mem_rdata_in;
  logic mem_wr_out;
  logic [1:0] mem_bank_out;
  logic [3:0] modified_nibble_out;
  logic run_out;
  int wcount;
  int n_errors = 0;
  int n_checks = 0;

  always #12.5 clk_in = ~clk_in;

  vpw_engine vpw_engine_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .mem_addr_out(mem_addr_out),
    .mem_rd_out(mem_rd_out), .mem_rdata_in(mem_rdata_in), .mem_wr_out(mem_wr_out),
    .mem_bank_out(mem_bank_out), .modified_nibble_out(modified_nibble_out),
    .run_out(run_out));

  vpw_screen_model vpw_screen_model_inst (.clk_in(clk_in), .mem_addr_in(mem_addr_out),
    .mem_rd_in(mem_rd_out), .mem_wr_in(mem_wr_out), .mem_bank_in(mem_bank_out),
    .nibble_in(modified_nibble_out), .rdata_out(mem_rdata_in), .wr_count_out(wcount));

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Entered just after a rising edge; sampled values are those seen by that edge
  task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    avs_address_in <= a;
    avs_read_in <= rd;
    avs_write_in <= !rd;
    avs_writedata_in <= d;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    bus(1'b1, a, 32'h0, q);
  endtask

  task automatic draw(input logic [9:0] x, input logic [7:0] y, input logic [9:0] maj,
      input logic [9:0] mnr, input logic [7:0] pat, input logic [3:0] mul,
      input logic [3:0] dir, input logic [7:0] wo, input logic [9:0] err);
    logic [31:0] q;
    wr(vpw_pkg::OFF_MAJOR, 32'(maj));
    wr(vpw_pkg::OFF_MINOR, 32'(mnr));
    wr(vpw_pkg::OFF_ERROR, 32'(err));
    wr(vpw_pkg::OFF_WRITE_OPTIONS, 32'(wo));
    wr(vpw_pkg::OFF_DIRECTION, 32'(dir));
    wr(vpw_pkg::OFF_PAT_MULT, 32'(mul));
    wr(vpw_pkg::OFF_X, 32'(x));
    wr(vpw_pkg::OFF_Y, 32'(y));
    wr(vpw_pkg::OFF_PATTERN, 32'(pat));
    wr(vpw_pkg::OFF_EXECUTE, 32'h2);
    rd(vpw_pkg::OFF_STATUS, q);
    `CHK(q[0], 1'b1)
    while (q[0] !== 1'b0) rd(vpw_pkg::OFF_STATUS, q);
    rd(vpw_pkg::OFF_LENGTH, q);
    `CHK(q[9:0], 10'h000)
  endtask

  function automatic logic exp_bit(input logic [1:0] m, input logic p, input logic o);
    case (m)
      2'h0: return p | o;
      2'h1: return p;
      2'h2: return p ^ o;
      default: return o & ~p;
    endcase
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    logic [31:0] q;
    rd(vpw_pkg::OFF_PATTERN, q);
    `CHK(q[7:0], 8'hFF)
    rd(vpw_pkg::OFF_PAT_MULT, q);
    `CHK(q[3:0], 4'hF)
    rd(6'h30, q);
    `CHK(q, 32'h0)
    wr(vpw_pkg::OFF_MAJOR, 32'h4);
    wr(vpw_pkg::OFF_EXECUTE, 32'h1);
    rd(vpw_pkg::OFF_STATUS, q);
    `CHK(q[0], 1'b0)
  endtask

  task automatic t_modes;
    logic [31:0] q;
    logic [3:0] e;
    logic [7:0] y;
    int n0;
    for (int m = 0; m < 4; m++) begin
      y = 8'(8 + m);
      vpw_screen_model_inst.mem[{y, 6'h00}] = 12'h006;
      n0 = wcount;
      draw(10'h000, y, 10'h004, 10'h000, 8'hA0, 4'hF, 4'h0, 8'(m * 2), 10'h000);
      for (int i = 0; i < 4; i++) e[i] = exp_bit(2'(m), (i % 2) == 0, 4'h6 >> i);
      `CHK(vpw_screen_model_inst.mem[{y, 6'h00}], {8'h00, e})
      `CHK(wcount - n0, 4)
      rd(vpw_pkg::OFF_X, q);
      `CHK(q[9:0], 10'h004)
    end
  endtask

  task automatic t_negate;
    // Multiplier 1110 holds each pattern bit for two writes
    draw(10'h004, 8'd20, 10'h004, 10'h000, 8'hA0, 4'hE, 4'h0, 8'h01, 10'h000);
    `CHK(vpw_screen_model_inst.mem[{8'd20, 6'h00}], 12'h0C0)
  endtask

  task automatic t_dirs;
    logic [31:0] q;
    int n0;
    n0 = wcount;
    draw(10'h008, 8'd2, 10'h002, 10'h000, 8'hFF, 4'hF, 4'h6, 8'h00, 10'h000);
    `CHK(vpw_screen_model_inst.mem[{8'd2, 6'h00}], 12'h000)
    `CHK(vpw_screen_model_inst.mem[{8'd3, 6'h00}], 12'h100)
    `CHK(wcount - n0, 1)
    rd(vpw_pkg::OFF_Y, q);
    `CHK(q[7:0], 8'd4)
    draw(10'h000, 8'd31, 10'h002, 10'h000, 8'hFF, 4'hF, 4'h2, 8'h00, 10'h000);
    `CHK(vpw_screen_model_inst.mem[{8'd31, 6'h00}], 12'h000)
    `CHK(vpw_screen_model_inst.mem[{8'd30, 6'h00}], 12'h001)
    rd(vpw_pkg::OFF_Y, q);
    `CHK(q[7:0], 8'd29)
  endtask

  task automatic t_arb;
    logic [31:0] q;
    logic [9:0] e;
    logic [9:0] ex;
    logic [7:0] ey;
    logic c;
    int n0;
    n0 = wcount;
    e = 10'd300;
    ex = 10'd900;
    ey = 8'd200;
    c = 1'b0;
    // Long enough that the minor add carries out, so X-only steps occur too
    for (int i = 0; i < 600; i++) begin
      {c, e} = {1'b0, e} + 11'd590 + {10'h000, c};
      if (!c) begin
        e = e + 10'd600;
        ey = ey - 8'h01;
      end
      ex = ex - 10'h001;
    end
    // Error preloaded with half the major length
    draw(10'd900, 8'd200, 10'd600, 10'd590, 8'hFF, 4'hF, 4'hB, 8'h00, 10'd300);
    rd(vpw_pkg::OFF_ERROR, q);
    `CHK(q[9:0], e)
    rd(vpw_pkg::OFF_X, q);
    `CHK(q[9:0], ex)
    rd(vpw_pkg::OFF_Y, q);
    `CHK(q[7:0], ey)
    `CHK(wcount - n0, 600)
  endtask

  task automatic end_of_test;
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    t_regs();
    t_modes();
    t_negate();
    t_dirs();
    t_arb();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    end_of_test();
  end
endmodule
